// ### design/pas_pkg.sv
// Shared constants, types and helpers for the PCI address/data steering block
package pas_pkg;

  localparam int AD_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;

  localparam logic [31:0] AD_RST = 32'h0000_0000;
  localparam logic [3:0] BE_RST = 4'h0;
  localparam logic FRAME_N_RST = 1'b1;

  localparam logic ORDER_LITTLE = 1'b0;
  localparam logic ORDER_BIG = 1'b1;

  typedef enum logic [2:0] {
    PAS_IDLE = 3'b001,
    PAS_ADDR = 3'b010,
    PAS_DATA = 3'b100
  } pas_phase_t;

  // Byte lane reversal within one DWORD
  function automatic logic [31:0] swap_bytes(input logic [31:0] w);
    swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Byte enable reversal matching swap_bytes
  function automatic logic [3:0] swap_lanes(input logic [3:0] b);
    swap_lanes = {b[0], b[1], b[2], b[3]};
  endfunction

endpackage

// ### design/pas_lane_if.sv
// Carrier between the steering core and its byte order mapper
`timescale 1ns/100ps
interface pas_lane_if;
  logic big_endian;
  logic [31:0] drv_word;
  logic [31:0] drv_lanes;
  logic [31:0] rcv_lanes;
  logic [31:0] rcv_word;
  logic [3:0] rcv_be_n;
  logic [3:0] rcv_valid;

  modport core (
    output big_endian,
    output drv_word,
    input drv_lanes,
    output rcv_lanes,
    input rcv_word,
    output rcv_be_n,
    input rcv_valid
  );

  modport mapper (
    input big_endian,
    input drv_word,
    output drv_lanes,
    input rcv_lanes,
    output rcv_word,
    input rcv_be_n,
    output rcv_valid
  );
endinterface

// ### design/pas_lane_swap.sv
// Byte order mapper between logical DWORDs and bus byte lanes
`timescale 1ns/100ps
module pas_lane_swap (
  pas_lane_if.mapper lane
);

  // Same selection used in both directions
  always_comb begin
    if (lane.big_endian == pas_pkg::ORDER_BIG) begin
      lane.drv_lanes = pas_pkg::swap_bytes(lane.drv_word);
      lane.rcv_word = pas_pkg::swap_bytes(lane.rcv_lanes);
      lane.rcv_valid = pas_pkg::swap_lanes(~lane.rcv_be_n);
    end else begin
      lane.drv_lanes = lane.drv_word;
      lane.rcv_word = lane.rcv_lanes;
      lane.rcv_valid = ~lane.rcv_be_n;
    end
  end

endmodule

// ### design/pci_ad_bus_steering.sv
// PCI multiplexed address/data bus steering: phase tracking, direction, byte order
// What this block does
// - First clock carries address, later clocks data
// - Single address phase, then at least one data
// - Little-endian: MSB on bits 31..24
// - Big-endian: lanes reversed, MSB on bits 7..0
// - Initiator drives address and writes, releases for reads
// - Target receives address and writes, drives read data
// - Uninvolved: bus released, nothing driven
// - Outputs launched only from rising clock edges, except combinational tx_data_take_o
// - Bus captured only on rising clock edges
// - Low byte enable marks lane valid
// - Frame fall starts; frame high marks last phase
`timescale 1ns/100ps
module pci_ad_bus_steering (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Static configuration
  input wire logic big_endian_i,
  // Bus pins, sampled on the rising edge
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  input wire logic cycle_frame_n_i,
  input wire logic [3:0] command_byte_enable_n_i,
  // Transaction control from the master and target machines
  input wire logic init_start_i,
  input wire logic init_write_i,
  input wire logic [31:0] init_addr_i,
  input wire logic tgt_sel_i,
  input wire logic tgt_write_i,
  input wire logic data_xfer_i,
  // Data to be driven, logical byte order
  input wire logic [31:0] tx_data_i,
  output logic tx_data_take_o,
  // Captured address and data
  output logic [31:0] rx_addr_o,
  output logic rx_addr_valid_o,
  output logic [31:0] rx_data_o,
  output logic [3:0] rx_byte_valid_o,
  output logic rx_data_valid_o,
  // Status
  output logic initiator_o,
  output logic data_phase_o
);

  pas_pkg::pas_phase_t phase_reg;
  pas_pkg::pas_phase_t phase_next;
  logic frame_n_reg;
  logic init_role_reg;
  logic init_write_reg;
  logic [31:0] ad_reg;
  logic [31:0] ad_next;
  logic oe_reg;
  logic oe_next;
  logic [31:0] rx_addr_reg;
  logic rx_addr_valid_reg;
  logic [31:0] rx_data_reg;
  logic [3:0] rx_valid_reg;
  logic rx_data_valid_reg;
  logic frame_fall;
  logic last_done;
  logic drive_write;
  logic drive_read;
  logic receiving;

  pas_lane_if lane ();

  pas_lane_swap u_swap (
    .lane(lane.mapper)
  );

  assign lane.big_endian = big_endian_i;
  assign lane.drv_word = tx_data_i;
  assign lane.rcv_lanes = ad_i;
  assign lane.rcv_be_n = command_byte_enable_n_i;

  // Transaction starts on a sampled high-to-low frame edge
  assign frame_fall = frame_n_reg & ~cycle_frame_n_i;
  // Frame already high on the completing data phase means it was the last
  assign last_done = (phase_reg == pas_pkg::PAS_DATA) & data_xfer_i & cycle_frame_n_i;

  assign drive_write = init_role_reg & init_write_reg;
  assign drive_read = ~init_role_reg & tgt_sel_i & ~tgt_write_i;
  assign receiving = (phase_reg == pas_pkg::PAS_DATA) &
                     ((init_role_reg & ~init_write_reg) |
                      (~init_role_reg & tgt_sel_i & tgt_write_i));

  // A new word is consumed when a driven data phase completes
  assign tx_data_take_o = (phase_reg == pas_pkg::PAS_DATA) & data_xfer_i &
                          (drive_write | drive_read);

  // Phase tracking
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      pas_pkg::PAS_IDLE: begin
        if (init_start_i) begin
          phase_next = pas_pkg::PAS_ADDR;
        end else if (frame_fall) begin
          // The sampled cycle was the address phase
          phase_next = pas_pkg::PAS_DATA;
        end
      end
      pas_pkg::PAS_ADDR: begin
        phase_next = pas_pkg::PAS_DATA;
      end
      pas_pkg::PAS_DATA: begin
        if (last_done) begin
          phase_next = pas_pkg::PAS_IDLE;
        end
      end
      default: begin
        phase_next = pas_pkg::PAS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      phase_reg <= pas_pkg::PAS_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      frame_n_reg <= pas_pkg::FRAME_N_RST;
    end else begin
      frame_n_reg <= cycle_frame_n_i;
    end
  end

  // Role and direction, held for the whole transaction
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      init_role_reg <= 1'b0;
      init_write_reg <= 1'b0;
    end else if (phase_reg == pas_pkg::PAS_IDLE && init_start_i) begin
      init_role_reg <= 1'b1;
      init_write_reg <= init_write_i;
    end else if (last_done) begin
      init_role_reg <= 1'b0;
      init_write_reg <= 1'b0;
    end
  end

  // Next drive value and enable, registered so pins move only at the edge
  always_comb begin
    ad_next = ad_reg;
    oe_next = 1'b0;
    case (phase_reg)
      pas_pkg::PAS_IDLE: begin
        if (init_start_i) begin
          ad_next = init_addr_i;
          oe_next = 1'b1;
        end
      end
      pas_pkg::PAS_ADDR: begin
        if (init_write_reg) begin
          ad_next = lane.drv_lanes;
          oe_next = 1'b1;
        end
      end
      pas_pkg::PAS_DATA: begin
        if (!last_done && (drive_write || drive_read)) begin
          oe_next = 1'b1;
          // Hold the word through wait states, fetch a new one on completion
          if (data_xfer_i || !oe_reg) begin
            ad_next = lane.drv_lanes;
          end
        end
      end
      default: begin
        oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ad_reg <= pas_pkg::AD_RST;
    end else begin
      ad_reg <= ad_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // Address capture as a target candidate
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_addr_reg <= pas_pkg::AD_RST;
      rx_addr_valid_reg <= 1'b0;
    end else begin
      rx_addr_valid_reg <= 1'b0;
      if (phase_reg == pas_pkg::PAS_IDLE && !init_start_i && frame_fall) begin
        rx_addr_reg <= ad_i;
        rx_addr_valid_reg <= 1'b1;
      end
    end
  end

  // Data capture; lanes flagged invalid still arrive but are marked
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_data_reg <= pas_pkg::AD_RST;
      rx_valid_reg <= pas_pkg::BE_RST;
      rx_data_valid_reg <= 1'b0;
    end else begin
      rx_data_valid_reg <= 1'b0;
      if (receiving && data_xfer_i) begin
        rx_data_reg <= lane.rcv_word;
        rx_valid_reg <= lane.rcv_valid;
        rx_data_valid_reg <= 1'b1;
      end
    end
  end

  assign ad_o = ad_reg;
  assign ad_oe_o = oe_reg;
  assign rx_addr_o = rx_addr_reg;
  assign rx_addr_valid_o = rx_addr_valid_reg;
  assign rx_data_o = rx_data_reg;
  assign rx_byte_valid_o = rx_valid_reg;
  assign rx_data_valid_o = rx_data_valid_reg;
  assign initiator_o = init_role_reg;
  assign data_phase_o = (phase_reg == pas_pkg::PAS_DATA);

endmodule

// ### sim/pas_assertions.sv
// Checker for the PCI address/data steering block
`timescale 1ns/100ps
module pas_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Configuration and bus inputs
  input wire logic big_endian_i,
  input wire logic [31:0] ad_i,
  input wire logic cycle_frame_n_i,
  input wire logic [3:0] command_byte_enable_n_i,
  // Transaction control
  input wire logic init_start_i,
  input wire logic init_write_i,
  input wire logic [31:0] init_addr_i,
  input wire logic tgt_sel_i,
  input wire logic tgt_write_i,
  input wire logic data_xfer_i,
  input wire logic [31:0] tx_data_i,
  // Watched outputs
  input wire logic [31:0] ad_o,
  input wire logic ad_oe_o,
  input wire logic tx_data_take_o,
  input wire logic [31:0] rx_addr_o,
  input wire logic rx_addr_valid_o,
  input wire logic [31:0] rx_data_o,
  input wire logic [3:0] rx_byte_valid_o,
  input wire logic rx_data_valid_o,
  input wire logic initiator_o,
  input wire logic data_phase_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire idle = !initiator_o && !data_phase_o;
  function automatic logic [31:0] sw(input logic [31:0] w, input logic b);
    sw = b ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction
  function automatic logic [3:0] sl(input logic [3:0] v, input logic b);
    sl = b ? {v[0], v[1], v[2], v[3]} : v;
  endfunction
  sequence s_capture;
    data_xfer_i && data_phase_o && !ad_oe_o && (initiator_o || tgt_sel_i && tgt_write_i);
  endsequence
  sequence s_addr_then_float;
    ad_oe_o ##1 !ad_oe_o;
  endsequence
  a_addr_drive: assert property (init_start_i && idle |=>
    ad_oe_o && initiator_o && ad_o == $past(init_addr_i)) else $error("bad address drive");
  a_read_release: assert property (init_start_i && !init_write_i && idle |=>
    s_addr_then_float) else $error("read bus not released");
  a_last_release: assert property (initiator_o && data_xfer_i && cycle_frame_n_i |=>
    !ad_oe_o && !initiator_o) else $error("no release after last phase");
  a_no_drive_idle: assert property (!initiator_o && !tgt_sel_i && !$past(tgt_sel_i) |->
    !ad_oe_o) else $error("bus driven while uninvolved");
  a_tgt_addr: assert property ($past(cycle_frame_n_i) && !cycle_frame_n_i && idle &&
    !init_start_i |=> rx_addr_valid_o && data_phase_o && rx_addr_o == $past(ad_i))
    else $error("target address not captured");
  a_rx_data: assert property (s_capture |=> rx_data_valid_o &&
    rx_data_o == sw($past(ad_i), big_endian_i)) else $error("bad received word");
  a_rx_lanes: assert property (s_capture |=>
    rx_byte_valid_o == sl(~$past(command_byte_enable_n_i), big_endian_i))
    else $error("bad byte valids");
  a_write_data: assert property (tx_data_take_o && !cycle_frame_n_i |=>
    ad_oe_o && ad_o == sw($past(tx_data_i), big_endian_i)) else $error("bad driven word");
  a_tgt_turn: assert property (data_phase_o && !initiator_o && tgt_sel_i && !tgt_write_i &&
    !ad_oe_o && !data_xfer_i |=> ad_oe_o && ad_o == sw($past(tx_data_i), big_endian_i))
    else $error("target read not driven");
endmodule
bind pci_ad_bus_steering pas_assertions u_chk (.*);

// ### sim/pas_far_agent.sv
// Far-side bus agent: resolves the shared address/data lines
`timescale 1ns/100ps
module pas_far_agent (
  input wire logic clk_i,
  input wire logic dev_oe_i,
  input wire logic [31:0] dev_ad_i,
  input wire logic agt_oe_i,
  input wire logic [31:0] agt_ad_i,
  output logic [31:0] bus_o
);
  logic [31:0] last_reg = 32'h0;
  always @(posedge clk_i) last_reg <= bus_o;
  always_comb begin
    if (dev_oe_i) bus_o = dev_ad_i;
    else if (agt_oe_i) bus_o = agt_ad_i;
    else bus_o = ~last_reg; // Released lines must not look stable
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the PCI address/data steering block
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'h0, rst_b_i = 1'h0, big = 1'h0, frame_n = 1'h1, start = 1'h0, wr = 1'h0;
  logic sel = 1'h0, twr = 1'h0, xfer = 1'h0, agt_oe = 1'h0;
  logic [31:0] addr = 32'h0, txd = 32'h0, agt_ad = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] bus, ad_o, rx_addr, rx_data;
  logic [3:0] rx_bv;
  logic oe, take, rxav, rxdv, init, dph;
  int checked = 0, n_mismatch = 0;
  pas_far_agent AGT (.clk_i(clk_i), .dev_oe_i(oe), .dev_ad_i(ad_o), .agt_oe_i(agt_oe),
    .agt_ad_i(agt_ad), .bus_o(bus));
  pci_ad_bus_steering DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .big_endian_i(big), .ad_i(bus),
    .ad_o(ad_o), .ad_oe_o(oe), .cycle_frame_n_i(frame_n), .command_byte_enable_n_i(be),
    .init_start_i(start), .init_write_i(wr), .init_addr_i(addr), .tgt_sel_i(sel),
    .tgt_write_i(twr), .data_xfer_i(xfer), .tx_data_i(txd), .tx_data_take_o(take),
    .rx_addr_o(rx_addr), .rx_addr_valid_o(rxav), .rx_data_o(rx_data),
    .rx_byte_valid_o(rx_bv), .rx_data_valid_o(rxdv), .initiator_o(init), .data_phase_o(dph));
  function automatic logic [31:0] mp(input logic [31:0] w);
    mp = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction
  function automatic logic [3:0] ml(input logic [3:0] v);
    ml = big ? {v[0], v[1], v[2], v[3]} : v;
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  task init_write;
    start = 1'h1;
    wr = 1'h1;
    addr = 32'h1000_0040;
    txd = 32'h1122_3344;
    tick;
    chk(40'({oe, init, ad_o}), 40'({2'h3, addr}));
    start = 1'h0;
    frame_n = 1'h0;
    tick;
    chk(40'({dph, oe, ad_o}), 40'({2'h3, mp(32'h1122_3344)}));
    txd = 32'hA5B6_C7D8;
    tick;
    // Wait state: the first word must still stand
    chk(40'({take, oe, ad_o}), 40'({2'h1, mp(32'h1122_3344)}));
    xfer = 1'h1;
    #1 chk(40'(take), 40'h1);
    tick;
    chk(40'({oe, ad_o}), 40'({1'h1, mp(32'hA5B6_C7D8)}));
    frame_n = 1'h1;
    tick;
    chk(40'({oe, init}), 40'h0);
    xfer = 1'h0;
  endtask
  task init_read;
    start = 1'h1;
    wr = 1'h0;
    addr = 32'h0000_2008;
    tick;
    chk(40'({oe, ad_o}), 40'({1'h1, addr}));
    start = 1'h0;
    frame_n = 1'h0;
    tick;
    chk(40'(oe), 40'h0);
    agt_oe = 1'h1;
    agt_ad = 32'h0102_0304;
    be = 4'h5;
    xfer = 1'h1;
    frame_n = 1'h1;
    tick;
    chk(40'({rxdv, rx_bv}), 40'({1'h1, ml(4'hA)}));
    chk(40'(rx_data), 40'(mp(32'h0102_0304)));
    agt_oe = 1'h0;
    xfer = 1'h0;
  endtask
  task tgt_write;
    frame_n = 1'h0;
    agt_oe = 1'h1;
    agt_ad = 32'h0000_3000;
    tick;
    chk(40'({rxav, dph, rx_addr}), 40'({2'h3, 32'h0000_3000}));
    agt_ad = 32'hDEAD_BEEF;
    be = 4'h8;
    sel = 1'h1;
    twr = 1'h1;
    xfer = 1'h1;
    frame_n = 1'h1;
    // A start outside idle must be ignored
    start = 1'h1;
    tick;
    chk(40'({oe, init, rxdv, rx_bv}), 40'({3'h1, ml(4'h7)}));
    chk(40'(rx_data), 40'(mp(32'hDEAD_BEEF)));
    agt_oe = 1'h0;
    sel = 1'h0;
    xfer = 1'h0;
    start = 1'h0;
  endtask
  task tgt_read;
    frame_n = 1'h0;
    agt_oe = 1'h1;
    agt_ad = 32'h0000_4004;
    tick;
    agt_oe = 1'h0;
    sel = 1'h1;
    twr = 1'h0;
    txd = 32'h7788_99AA;
    tick;
    chk(40'({oe, ad_o}), 40'({1'h1, mp(32'h7788_99AA)}));
    xfer = 1'h1;
    frame_n = 1'h1;
    tick;
    chk(40'({oe, dph}), 40'h0);
    sel = 1'h0;
    xfer = 1'h0;
  endtask
  task uninvolved;
    frame_n = 1'h0;
    agt_oe = 1'h1;
    agt_ad = 32'h0000_5000;
    tick;
    agt_ad = 32'h0BAD_F00D;
    xfer = 1'h1;
    frame_n = 1'h1;
    tick;
    chk(40'({oe, rxdv}), 40'h0);
    agt_oe = 1'h0;
    xfer = 1'h0;
  endtask
  // Reset in the middle of a driven write, then a target access right after release
  task mid_reset;
    start = 1'h1;
    wr = 1'h1;
    addr = 32'h0000_6000;
    txd = 32'h0F1E_2D3C;
    tick;
    start = 1'h0;
    frame_n = 1'h0;
    tick;
    chk(40'({dph, oe}), 40'h3);
    rst_b_i = 1'h0;
    tick;
    chk(40'({oe, init, dph, rxav, rxdv, ad_o}), 40'h0);
    rst_b_i = 1'h1;
    agt_oe = 1'h1;
    agt_ad = 32'h0000_7000;
    tick;
    chk(40'({rxav, dph, oe, init, rx_addr}), 40'({4'hC, 32'h0000_7000}));
    agt_ad = 32'h5566_7788;
    be = 4'h3;
    sel = 1'h1;
    twr = 1'h1;
    xfer = 1'h1;
    frame_n = 1'h1;
    tick;
    chk(40'({oe, rxdv, rx_bv}), 40'({2'h1, ml(4'hC)}));
    chk(40'(rx_data), 40'(mp(32'h5566_7788)));
    agt_oe = 1'h0;
    sel = 1'h0;
    xfer = 1'h0;
  endtask
  task tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (2) tick;
    chk(40'({oe, init, dph, rxav, rxdv}), 40'h0);
    rst_b_i = 1'h1;
    for (int b = 0; b < 2; b++) begin
      big = b[0];
      init_write;
      init_read;
      tgt_write;
      tgt_read;
      uninvolved;
    end
    mid_reset;
    tally_and_finish;
  end
endmodule
